// >>> core/rts_pkg.sv
// Purpose: Constants, types and helpers of the reset time-out sequencer
// Assumes: 200 MHz core clock, synchronous detector and fuse inputs
// Notes: Register byte address is four times the register index
// Operation
// - Power-up delay 64 ms from RC oscillator
// - Core held in reset while delay runs
// - Delay enable fuse is active low
// - Mode 10 turns brown-out off in sleep
// - Sustained low supply enters brown-out reset
// - Reset held until supply good, then delay
// - Brown-out during delay restarts the delay
// - Delay starts after power-on pulse ends
// - Crystal modes add 1024-period oscillator start-up
// - Other clock modes skip oscillator start-up
// - Time-outs run regardless of reset pin
// - Power-control bit 0: active-low brown-out flag
// - Power-control bit 1: active-low power-on flag
// - Watchdog and powerdown flags follow reset cause
// - Brown-out modes: 11 on, 10 run, 0x off
package rts_pkg;

	localparam int CLK_PERIOD_NS = 5;
	localparam int POWERUP_DELAY_TIMER_TIME_MS = 64;
	localparam int RC_PERIOD_NS = 1000;
	localparam int RC_DIV = RC_PERIOD_NS / CLK_PERIOD_NS;
	localparam int POWERUP_DELAY_TIMER_TICKS = POWERUP_DELAY_TIMER_TIME_MS * 1000000 / RC_PERIOD_NS;
	localparam int OST_PERIODS = 1024;

	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] POWER_CONTROL_FLAGS_IDX = 12'h08E;
	localparam logic [ADDR_W-1:0] STATUS_IDX = 12'h003;
	localparam logic [ADDR_W-1:0] CTRL_IDX = 12'h090;

	localparam int POWER_CONTROL_FLAGS_BOR_BIT = 0;
	localparam int POWER_CONTROL_FLAGS_POR_BIT = 1;
	localparam int STAT_PD_BIT = 3;
	localparam int STAT_TO_BIT = 4;
	localparam int CTRL_SLEEP_BIT = 0;
	localparam int CTRL_STATE_LSB = 4;

	localparam logic [1:0] BOR_ALWAYS = 2'h3;
	localparam logic [1:0] BOR_RUN_ONLY = 2'h2;
	localparam logic [2:0] OSC_HS = 3'h2;
	localparam logic [1:0] POWER_CONTROL_FLAGS_RST = 2'h0;

	typedef enum logic [2:0] {
		ST_HOLD = 3'h0,
		ST_POWERUP_DELAY_TIMER = 3'h1,
		ST_OST = 3'h3,
		ST_RUN = 3'h2,
		ST_SLEEP = 3'h6,
		ST_WAKE = 3'h7
	} rts_state_t;

	typedef struct packed {
		logic pwrtEnN;
		logic [1:0] borModeSel;
		logic [2:0] oscModeSel;
	} rts_cfg_t;

	typedef struct packed {
		logic porPulse;
		logic brownoutDet;
		logic extResetPinN;
		logic wdtTimeout;
		logic wakeIrq;
	} rts_det_t;

	// Crystal modes are the codes at or below the high-speed one
	function automatic logic rts_is_crystal(input logic [2:0] osc);
		return osc <= OSC_HS;
	endfunction : rts_is_crystal

	function automatic logic rts_bor_armed(input logic [1:0] mode, input logic sleeping);
		return (mode == BOR_ALWAYS) || ((mode == BOR_RUN_ONLY) && !sleeping);
	endfunction : rts_bor_armed

endpackage : rts_pkg

// >>> core/rts_tick_counter.sv
// Purpose: Counts enable ticks up to a terminal count
// Assumes: Clear has priority over counting
// Notes: Done is a level while the count sits at its terminal
`timescale 1ns/10ps
module rts_tick_counter #(
	parameter int TERM = 1024
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clr,
	input wire logic run,
	input wire logic tick,
	output logic done
);

	localparam int CW = $clog2(TERM + 1);
	localparam logic [CW-1:0] TERM_C = CW'(TERM);

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		if (clr) begin
			cnt_d = '0;
		end else if (run && tick && cnt_q != TERM_C) begin
			cnt_d = cnt_q + CW'(1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign done = (cnt_q == TERM_C);

endmodule : rts_tick_counter

// >>> core/rts_sequencer.sv
// Purpose: Reset time-out sequencer with reset-cause flags on AHB-Lite
// Assumes: Detector, pin and fuse inputs synchronous to core_clk
// Notes: Zero-wait-state slave, read data sampled at address phase
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/10ps
module rts_sequencer
	import rts_pkg::*;
#(
	parameter int POWERUP_DELAY_TIMER_TERM = POWERUP_DELAY_TIMER_TICKS,
	parameter int OST_TERM = OST_PERIODS,
	parameter int RC_TICK_DIV = RC_DIV
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire rts_cfg_t cfg,
	input wire rts_det_t det,
	input wire logic oscPeriodTick,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic coreResetOut,
	output logic borDetectEnable,
	output logic sleepActive
);

	////////////////////////////////////////////////////////////////////////////
	// RC oscillator stand-in and time-out counters

	localparam int DW = $clog2(RC_TICK_DIV + 1);
	localparam logic [DW-1:0] DIV_LAST = DW'(RC_TICK_DIV - 1);

	rts_state_t state_q, state_d;
	logic [DW-1:0] div_q, div_d;
	logic rcTick;
	logic pwrtDone;
	logic ostDone;

	always_comb begin
		div_d = (div_q == DIV_LAST) ? '0 : div_q + DW'(1);
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			div_q <= '0;
		end else begin
			div_q <= div_d;
		end
	end

	assign rcTick = (div_q == DIV_LAST);

	// delay counter, cleared outside its state
	rts_tick_counter #(
		.TERM(POWERUP_DELAY_TIMER_TERM)
	) u_powerup_delay_timer (
		.core_clk(core_clk),
		.rst(rst),
		.clr(state_q != ST_POWERUP_DELAY_TIMER),
		.run(state_q == ST_POWERUP_DELAY_TIMER),
		.tick(rcTick),
		.done(pwrtDone)
	);

	rts_tick_counter #(
		.TERM(OST_TERM)
	) u_ost (
		.core_clk(core_clk),
		.rst(rst),
		.clr(state_q != ST_OST && state_q != ST_WAKE),
		.run(state_q == ST_OST || state_q == ST_WAKE),
		.tick(oscPeriodTick),
		.done(ostDone)
	);

	////////////////////////////////////////////////////////////////////////////
	// Sequencer

	logic sleeping;
	logic borTrip;
	logic powerRst;
	logic crystal;
	logic sleepReq;
	logic causePwr_q, causePwr_d;
	logic coreRst_q, coreRst_d;

	assign sleeping = (state_q == ST_SLEEP);
	assign crystal = rts_is_crystal(cfg.oscModeSel);
	// detector armed per mode and sleep
	assign borDetectEnable = rts_bor_armed(cfg.borModeSel, sleeping);
	assign borTrip = det.brownoutDet && borDetectEnable;
	assign powerRst = det.porPulse || borTrip;

	always_comb begin
		state_d = state_q;
		causePwr_d = causePwr_q;
		if (powerRst) begin
			// back to hold, delay restarts later
			state_d = ST_HOLD;
			causePwr_d = 1'b1;
		end else begin
			case (state_q)
				ST_HOLD: begin
					if (!causePwr_q) begin
						state_d = ST_RUN;
					end else if (!cfg.pwrtEnN) begin
						state_d = ST_POWERUP_DELAY_TIMER;
					end else if (crystal) begin
						state_d = ST_OST;
					end else begin
						state_d = ST_RUN;
					end
				end
				ST_POWERUP_DELAY_TIMER: begin
					if (pwrtDone) begin
						state_d = crystal ? ST_OST : ST_RUN;
					end
				end
				ST_OST: begin
					if (ostDone) begin
						state_d = ST_RUN;
					end
				end
				ST_RUN: begin
					if (det.wdtTimeout) begin
						state_d = ST_HOLD;
						causePwr_d = 1'b0;
					end else if (sleepReq) begin
						state_d = ST_SLEEP;
					end
				end
				ST_SLEEP: begin
					if (!det.extResetPinN) begin
						state_d = ST_RUN;
					end else if (det.wdtTimeout || det.wakeIrq) begin
						state_d = crystal ? ST_WAKE : ST_RUN;
					end
				end
				ST_WAKE: begin
					if (ostDone) begin
						state_d = ST_RUN;
					end
				end
				default: begin
					state_d = ST_HOLD;
				end
			endcase
		end
		coreRst_d = !(state_d == ST_RUN || state_d == ST_SLEEP) || !det.extResetPinN;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_q <= ST_HOLD;
			causePwr_q <= 1'b1;
			coreRst_q <= 1'b1;
		end else begin
			state_q <= state_d;
			causePwr_q <= causePwr_d;
			coreRst_q <= coreRst_d;
		end
	end

	assign coreResetOut = coreRst_q;
	assign sleepActive = sleeping;

	////////////////////////////////////////////////////////////////////////////
	// Reset-cause flags

	logic porN_q, porN_d, borN_q, borN_d;
	logic to_q, to_d, pd_q, pd_d;
	logic wrPcon;

	always_comb begin
		porN_d = porN_q;
		borN_d = borN_q;
		to_d = to_q;
		pd_d = pd_q;
		if (wrPcon) begin
			porN_d = hwdata[POWER_CONTROL_FLAGS_POR_BIT];
			borN_d = hwdata[POWER_CONTROL_FLAGS_BOR_BIT];
		end
		if (det.porPulse) begin
			porN_d = 1'b0;
		end else if (borTrip) begin
			borN_d = 1'b0;
		end
		if (powerRst) begin
			to_d = 1'b1;
			pd_d = 1'b1;
		end else if (state_q == ST_RUN && det.wdtTimeout) begin
			to_d = 1'b0;
		end else if (sleeping && !det.extResetPinN) begin
			to_d = 1'b1;
			pd_d = 1'b0;
		end else if (sleeping && det.wdtTimeout) begin
			to_d = 1'b0;
			pd_d = 1'b0;
		end else if (state_q == ST_RUN && sleepReq) begin
			to_d = 1'b1;
			pd_d = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			{porN_q, borN_q} <= POWER_CONTROL_FLAGS_RST;
			to_q <= 1'b1;
			pd_q <= 1'b1;
		end else begin
			porN_q <= porN_d;
			borN_q <= borN_d;
			to_q <= to_d;
			pd_q <= pd_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave, no wait states, always OKAY

	logic dWr_q, dWr_d;
	logic [ADDR_W-1:0] dIdx_q, dIdx_d;
	logic [31:0] rd_q, rd_d;
	logic addrPhase;
	logic [ADDR_W-1:0] aIdx;

	assign addrPhase = hsel && htrans[1] && hready;
	assign aIdx = haddr[ADDR_W+1:2];
	assign wrPcon = dWr_q && (dIdx_q == POWER_CONTROL_FLAGS_IDX);
	assign sleepReq = dWr_q && (dIdx_q == CTRL_IDX) && hwdata[CTRL_SLEEP_BIT];

	always_comb begin
		dWr_d = addrPhase && hwrite;
		dIdx_d = aIdx;
		rd_d = rd_q;
		if (addrPhase && !hwrite) begin
			rd_d = '0;
			case (aIdx)
				POWER_CONTROL_FLAGS_IDX: begin
					rd_d[POWER_CONTROL_FLAGS_POR_BIT] = porN_q;
					rd_d[POWER_CONTROL_FLAGS_BOR_BIT] = borN_q;
				end
				STATUS_IDX: begin
					rd_d[STAT_TO_BIT] = to_q;
					rd_d[STAT_PD_BIT] = pd_q;
				end
				CTRL_IDX: begin
					rd_d[CTRL_STATE_LSB +: 3] = state_q;
				end
				default: begin
					rd_d = '0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			dWr_q <= 1'b0;
			dIdx_q <= '0;
			rd_q <= '0;
		end else begin
			dWr_q <= dWr_d;
			dIdx_q <= dIdx_d;
			rd_q <= rd_d;
		end
	end

	assign hrdata = rd_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	property p_hold_in_delay;
		state_q == ST_POWERUP_DELAY_TIMER |-> coreResetOut;
	endproperty
	a_hold_in_delay: assert property (p_hold_in_delay) else $error("core out of reset in delay");

	property p_bor_restart;
		borTrip && state_q == ST_POWERUP_DELAY_TIMER |=> state_q == ST_HOLD ##1 !pwrtDone;
	endproperty
	a_bor_restart: assert property (p_bor_restart) else $error("delay not restarted");

	property p_delay_off;
		state_q == ST_HOLD && causePwr_q && !powerRst && cfg.pwrtEnN |=> state_q != ST_POWERUP_DELAY_TIMER;
	endproperty
	a_delay_off: assert property (p_delay_off) else $error("delay ran while disabled");

	property p_sleep_bor;
		sleeping && cfg.borModeSel == BOR_RUN_ONLY |-> !borDetectEnable;
	endproperty
	a_sleep_bor: assert property (p_sleep_bor) else $error("detector on in sleep");

	property p_bor_flag;
		borTrip && !det.porPulse |=> !borN_q && coreResetOut;
	endproperty
	a_bor_flag: assert property (p_bor_flag) else $error("brown-out not flagged");

	property p_por_hold;
		det.porPulse |=> state_q == ST_HOLD && !porN_q && to_q && pd_q;
	endproperty
	a_por_hold: assert property (p_por_hold) else $error("power-on not handled");

	property p_ost_after;
		state_q == ST_POWERUP_DELAY_TIMER && pwrtDone && !powerRst && crystal |=> state_q == ST_OST;
	endproperty
	a_ost_after: assert property (p_ost_after) else $error("start-up skipped");

	property p_no_ost;
		state_q == ST_POWERUP_DELAY_TIMER && pwrtDone && !powerRst && !crystal |=> state_q == ST_RUN;
	endproperty
	a_no_ost: assert property (p_no_ost) else $error("start-up not skipped");

	property p_pin_release;
		state_q == ST_RUN && $rose(det.extResetPinN) && !powerRst && !det.wdtTimeout
			|=> !coreResetOut;
	endproperty
	a_pin_release: assert property (p_pin_release) else $error("late release");

	property p_pin_sleep;
		sleeping && !det.extResetPinN && !powerRst |=> to_q && !pd_q && coreResetOut;
	endproperty
	a_pin_sleep: assert property (p_pin_sleep) else $error("pin sleep flags wrong");

	c_power_up: cover property (state_q == ST_POWERUP_DELAY_TIMER ##1 state_q == ST_OST);
	c_wdt_wake: cover property (sleeping && det.wdtTimeout ##1 state_q == ST_WAKE);
	c_bor_in_delay: cover property (state_q == ST_POWERUP_DELAY_TIMER && borTrip);

endmodule : rts_sequencer

// >>> testbench/rts_supply_model.sv
// Purpose: Supply detectors, reset pin and crystal of the sequencer
// Assumes: Commands from the bench change right after a rising edge
// Notes: Brown-out is only reported while the detector is armed
`timescale 1ns/10ps
module rts_supply_model
	import rts_pkg::*;
(
	input wire logic core_clk,
	input wire logic porCmd,
	input wire logic lowCmd,
	input wire logic pinLowCmd,
	input wire logic wdtCmd,
	input wire logic wakeCmd,
	input wire logic borDetectEnable,
	output rts_det_t det,
	output logic oscPeriodTick
);
	logic [1:0] oscDiv = 2'h0;

	assign det = '{porPulse: porCmd, brownoutDet: lowCmd & borDetectEnable,
		extResetPinN: ~pinLowCmd, wdtTimeout: wdtCmd, wakeIrq: wakeCmd};
	// Crystal runs free, one period every three clocks
	always @(posedge core_clk) begin
		oscDiv <= (oscDiv == 2'h2) ? 2'h0 : oscDiv + 2'h1;
	end
	assign oscPeriodTick = (oscDiv == 2'h0);
endmodule : rts_supply_model

// >>> testbench/test_rts_sequencer.sv
// Purpose: Self-checking bench of the reset time-out sequencer
// Assumes: Shortened counts, delay 8 ticks of 2 clocks, start-up 4 periods
// Notes: Timeouts are checked with margins, the RC divider phase is free
`timescale 1ns/10ps
module test_rts_sequencer;
	import rts_pkg::*;
	localparam logic [31:0] POWER_CONTROL_FLAGS_A = 32'h0000_0238;
	localparam logic [31:0] STAT_A = 32'h0000_000C;
	localparam logic [31:0] CTRL_A = 32'h0000_0240;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	rts_cfg_t cfg = '{pwrtEnN: 1'b0, borModeSel: 2'h3, oscModeSel: 3'h4};
	rts_det_t det;
	logic oscPeriodTick;
	logic por = 1'b0;
	logic low = 1'b0;
	logic pinLow = 1'b0;
	logic wdt = 1'b0;
	logic wake = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic coreResetOut;
	logic borDetectEnable;
	logic sleepActive;
	int failures = 0;
	int num_checks = 0;

	always #2.5 core_clk = ~core_clk;

	rts_supply_model i_rts_supply_model (.core_clk(core_clk), .porCmd(por), .lowCmd(low),
		.pinLowCmd(pinLow), .wdtCmd(wdt), .wakeCmd(wake),
		.borDetectEnable(borDetectEnable), .det(det), .oscPeriodTick(oscPeriodTick));

	rts_sequencer #(.POWERUP_DELAY_TIMER_TERM(8), .OST_TERM(4), .RC_TICK_DIV(2)) i_rts_sequencer (
		.core_clk(core_clk), .rst(rst), .cfg(cfg), .det(det), .oscPeriodTick(oscPeriodTick),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .coreResetOut(coreResetOut), .borDetectEnable(borDetectEnable),
		.sleepActive(sleepActive));

	////////////////////////////////////////////////////////////////////////
	task automatic summarize;
		if (failures == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk(hresp, 1'b0);
	endtask : bus

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
		@(posedge core_clk);
	endtask : wr

	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] r;
		bus(1'b0, a, 32'h0000_0000, r);
		chk(r, exp);
	endtask : rd

	task automatic hold(input int n);
		repeat (n) begin
			@(posedge core_clk);
			chk(coreResetOut, 1'b1);
		end
	endtask : hold

	task automatic fall(input int n);
		int i;
		i = 0;
		while (coreResetOut !== 1'b0 && i < n) begin
			@(posedge core_clk);
			i++;
		end
		chk(coreResetOut, 1'b0);
	endtask : fall

	// Selector 0 watchdog, 1 wake, others reset pin
	task automatic pulse(input int which);
		case (which)
			0: begin
				wdt <= 1'b1;
			end
			1: begin
				wake <= 1'b1;
			end
			default: begin
				pinLow <= 1'b1;
			end
		endcase
		@(posedge core_clk);
		wdt <= 1'b0;
		wake <= 1'b0;
		pinLow <= 1'b0;
		repeat (4) @(posedge core_clk);
	endtask : pulse

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		hold(10);
		fall(30);
		rd(POWER_CONTROL_FLAGS_A, 32'h0000_0000);
		rd(STAT_A, 32'h0000_0018);
		wr(POWER_CONTROL_FLAGS_A, 32'h0000_0003);
		rd(POWER_CONTROL_FLAGS_A, 32'h0000_0003);
		rd(32'h0000_0100, 32'h0000_0000);
		rd(CTRL_A, 32'h0000_0020);
		// Brown-out again while the delay runs
		low <= 1'b1;
		repeat (3) @(posedge core_clk);
		low <= 1'b0;
		repeat (8) @(posedge core_clk);
		low <= 1'b1;
		@(posedge core_clk);
		low <= 1'b0;
		hold(12);
		fall(30);
		rd(POWER_CONTROL_FLAGS_A, 32'h0000_0002);
		rd(STAT_A, 32'h0000_0018);
		wr(POWER_CONTROL_FLAGS_A, 32'h0000_0003);
		pulse(0);
		fall(4);
		rd(STAT_A, 32'h0000_0008);
		pinLow <= 1'b1;
		@(posedge core_clk);
		hold(20);
		pinLow <= 1'b0;
		fall(4);
		rd(STAT_A, 32'h0000_0008);
		por <= 1'b1;
		@(posedge core_clk);
		hold(30);
		por <= 1'b0;
		hold(10);
		fall(30);
		rd(POWER_CONTROL_FLAGS_A, 32'h0000_0001);
		rd(STAT_A, 32'h0000_0018);
		wr(POWER_CONTROL_FLAGS_A, 32'h0000_0003);
		// Time-outs expire while the pin is still low
		por <= 1'b1;
		pinLow <= 1'b1;
		repeat (3) @(posedge core_clk);
		por <= 1'b0;
		repeat (40) @(posedge core_clk);
		pinLow <= 1'b0;
		fall(3);
		for (int m = 0; m < 2; m++) begin
			cfg.borModeSel <= 2'(m);
			low <= 1'b1;
			repeat (5) @(posedge core_clk);
			chk(borDetectEnable, 1'b0);
			chk(coreResetOut, 1'b0);
			low <= 1'b0;
		end
		cfg.borModeSel <= 2'h2;
		wr(CTRL_A, 32'h0000_0001);
		chk(sleepActive, 1'b1);
		chk(borDetectEnable, 1'b0);
		rd(STAT_A, 32'h0000_0010);
		pulse(1);
		chk(sleepActive, 1'b0);
		chk(borDetectEnable, 1'b1);
		cfg.borModeSel <= 2'h3;
		wr(CTRL_A, 32'h0000_0001);
		chk(borDetectEnable, 1'b1);
		pulse(0);
		rd(STAT_A, 32'h0000_0000);
		wr(CTRL_A, 32'h0000_0001);
		pulse(2);
		fall(5);
		rd(STAT_A, 32'h0000_0010);
		// Delay off and brown-out mode set off, every clock mode in turn
		for (int o = 0; o < 8; o++) begin
			cfg <= '{pwrtEnN: 1'b1, borModeSel: 2'h0, oscModeSel: 3'(o)};
			rst <= 1'b1;
			repeat (2) @(posedge core_clk);
			rst <= 1'b0;
			if (o <= 2) begin
				hold(6);
				fall(30);
			end else begin
				fall(5);
			end
		end
		cfg <= '{pwrtEnN: 1'b0, borModeSel: 2'h3, oscModeSel: 3'h2};
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		hold(20);
		fall(30);
		// Crystal wake runs the start-up count with the core held
		wr(CTRL_A, 32'h0000_0001);
		pulse(0);
		chk(sleepActive, 1'b0);
		chk(coreResetOut, 1'b1);
		fall(30);
		rd(STAT_A, 32'h0000_0000);
		summarize();
	end

	// Whole run needs well under 2000 cycles
	initial begin
		#20000;
		failures++;
		summarize();
	end
endmodule : test_rts_sequencer
